// ---- ddstw_pkg.sv ----
`default_nettype none

package ddstw_pkg;

	// ********************************************************
	// Widths
	// ********************************************************
	localparam int FTW_W       = 48;
	localparam int POW_W       = 14;
	localparam int STRAP_W     = 4;
	localparam int NUM_BYTES   = 8;
	localparam int NUM_FTW_B   = 6;
	localparam int ADDR_W      = 12;

	// ********************************************************
	// Register indices; the byte address is four times these
	// ********************************************************
	localparam logic [9:0] IDX_TW_BYTE0   = 10'h1A6;
	localparam logic [9:0] IDX_TW_BYTE1   = 10'h1A7;
	localparam logic [9:0] IDX_TW_BYTE2   = 10'h1A8;
	localparam logic [9:0] IDX_TW_BYTE3   = 10'h1A9;
	localparam logic [9:0] IDX_TW_BYTE4   = 10'h1AA;
	localparam logic [9:0] IDX_TW_BYTE5   = 10'h1AB;
	localparam logic [9:0] IDX_PHASE_LOW  = 10'h1AC;
	localparam logic [9:0] IDX_PHASE_HIGH = 10'h1AD;
	localparam logic [9:0] IDX_PHASE_NOW  = 10'h1AE;
	localparam logic [9:0] IDX_STRAP_RD   = 10'h1AF;

	// ********************************************************
	// Decode slots, field masks, reset values, responses
	// ********************************************************
	localparam logic [3:0] SLOT_PHASE_NOW = 4'h8;
	localparam logic [3:0] SLOT_STRAP     = 4'h9;
	localparam logic [3:0] SLOT_NONE      = 4'hF;
	localparam logic [7:0] POW_HIGH_MASK  = 8'h3F;
	localparam logic [7:0] BYTE_RESET     = 8'h00;
	localparam logic [FTW_W-1:0] ACC_RESET = 48'h0;
	localparam logic [POW_W-1:0] PHASE_RESET = 14'h0;
	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_DECERR    = 2'h3;
	localparam logic [31:0] WORD_ZERO     = 32'h0;

	// ********************************************************
	// Types
	// ********************************************************
	typedef struct packed {
		logic [FTW_W-1:0] frequency_tuning_word;
		logic [POW_W-1:0] phase_offset_word;
	} ddstw_cfg_t;

	typedef enum logic [1:0] {
		ST_STRAP = 2'b01,
		ST_RUN   = 2'b10
	} ddstw_state_t;

	// ********************************************************
	// Functions
	// ********************************************************
	function automatic logic [3:0] ddstw_slot(
		input logic [ADDR_W-1:0] addr
	);
		logic [9:0] idx;
		idx = addr[ADDR_W-1:2];
		if (idx >= IDX_TW_BYTE0 && idx <= IDX_PHASE_HIGH)
			ddstw_slot = 4'(idx - IDX_TW_BYTE0);
		else if (idx == IDX_PHASE_NOW)
			ddstw_slot = SLOT_PHASE_NOW;
		else if (idx == IDX_STRAP_RD)
			ddstw_slot = SLOT_STRAP;
		else
			ddstw_slot = SLOT_NONE;
	endfunction

	// The strap value picks one of sixteen evenly spread tuning words.
	function automatic logic [FTW_W-1:0] ddstw_default(
		input logic [STRAP_W-1:0] strap
	);
		ddstw_default = {4'h0, strap, 40'h0};
	endfunction

endpackage

`default_nettype wire

// ---- ddstw_bytereg.sv ----
`timescale 1ns/1ps
`default_nettype none

module ddstw_bytereg
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       load,
	input  wire logic [7:0] load_val,
	input  wire logic       wr,
	input  wire logic [7:0] wdata,
	output var  logic [7:0] q
);
	import ddstw_pkg::*;

	// ********************************************************
	// Byte storage
	// ********************************************************
	// The strap load outranks a bus write; they never overlap
	// because the bus is held off while the strap is taken.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			q <= BYTE_RESET;
		else if (load)
			q <= load_val;
		else if (wr)
			q <= wdata;
	end

endmodule

`default_nettype wire

// ---- ddstw_accum.sv ----
`timescale 1ns/1ps
`default_nettype none

module ddstw_accum
(
	input  wire logic                            aclk,
	input  wire logic                            aresetn,
	input  wire ddstw_pkg::ddstw_cfg_t           cfg,
	output var  logic [ddstw_pkg::POW_W-1:0]     phase_out
);
	import ddstw_pkg::*;

	logic [FTW_W-1:0] acc;
	logic [FTW_W-1:0] next_acc;
	logic [POW_W-1:0] next_phase;

	// ********************************************************
	// Phase accumulator and offset
	// ********************************************************
	// A new tuning word only changes the step; the accumulator
	// is cleared only by reset, so the phase stays continuous.
	assign next_acc = acc + cfg.frequency_tuning_word;
	assign next_phase = acc[FTW_W-1 -: POW_W]
		+ cfg.phase_offset_word;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			acc       <= ACC_RESET;
			phase_out <= PHASE_RESET;
		end
		else
		begin
			acc       <= next_acc;
			phase_out <= next_phase;
		end
	end

endmodule

`default_nettype wire

// ---- ddstw_top.sv ----
// Operation
// - Accumulator advances by the 48-bit tuning word every system clock.
// - Tuning bytes 3,4,5 hold bits 31:24, 39:32, 47:40; LSB lowest address.
// - At power-up the tuning word loads a strap-selected default value.
// - New tuning word changes frequency at once, keeping accumulated phase.
// - Phase offset is 14 bits: low byte 7:0, high byte 13:8.
// - Phase offset is added to the accumulator phase.
// - Brief phase glitches at 45 degree offset steps are tolerated.
// - Tuning bytes 1 and 2 hold bits 15:8 and 23:16.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module ddstw_top
(
	input  wire logic                               aclk,
	input  wire logic                               aresetn,
	input  wire logic [ddstw_pkg::ADDR_W-1:0]       s_axi_awaddr,
	input  wire logic [2:0]                         s_axi_awprot,
	input  wire logic                               s_axi_awvalid,
	output var  logic                               s_axi_awready,
	input  wire logic [31:0]                        s_axi_wdata,
	input  wire logic [3:0]                         s_axi_wstrb,
	input  wire logic                               s_axi_wvalid,
	output var  logic                               s_axi_wready,
	output var  logic [1:0]                         s_axi_bresp,
	output var  logic                               s_axi_bvalid,
	input  wire logic                               s_axi_bready,
	input  wire logic [ddstw_pkg::ADDR_W-1:0]       s_axi_araddr,
	input  wire logic [2:0]                         s_axi_arprot,
	input  wire logic                               s_axi_arvalid,
	output var  logic                               s_axi_arready,
	output var  logic [31:0]                        s_axi_rdata,
	output var  logic [1:0]                         s_axi_rresp,
	output var  logic                               s_axi_rvalid,
	input  wire logic                               s_axi_rready,
	input  wire logic [ddstw_pkg::STRAP_W-1:0]      startup_strap,
	output var  logic [ddstw_pkg::POW_W-1:0]        dds_phase
);
	import ddstw_pkg::*;

	// ********************************************************
	// Declarations
	// ********************************************************
	ddstw_state_t         state;
	ddstw_state_t         next_state;
	logic                 strap_load;
	logic                 run_next;
	logic [STRAP_W-1:0]   strap_q;
	logic [STRAP_W-1:0]   next_strap;
	logic [FTW_W-1:0]     strap_default;

	// Register bytes and the words built from them.
	logic [7:0]           byte_q [NUM_BYTES];
	ddstw_cfg_t           cfg;

	// Write channel: capture flags, held request, next values.
	logic                 aw_got;
	logic                 next_aw_got;
	logic [ADDR_W-1:0]    aw_addr_q;
	logic [ADDR_W-1:0]    next_aw_addr;
	logic                 w_got;
	logic                 next_w_got;
	logic [31:0]          w_data_q;
	logic [31:0]          next_w_data;
	logic [3:0]           w_strb_q;
	logic [3:0]           next_w_strb;
	logic                 aw_take;
	logic                 w_take;
	logic                 do_write;
	logic [3:0]           wr_slot;
	logic                 wr_lane0;
	logic                 next_bvalid;
	logic [1:0]           next_bresp;
	logic                 wr_unmapped;
	logic                 next_awready;
	logic                 next_wready;

	// Read channel.
	logic                 ar_take;
	logic [3:0]           rd_slot;
	logic [31:0]          rd_word;
	logic                 rd_is_byte;
	logic                 rd_is_live;
	logic                 rd_is_strap;
	logic                 rd_unmapped;
	logic [31:0]          rd_byte_word;
	logic [31:0]          rd_live_word;
	logic [31:0]          rd_strap_word;
	logic                 next_rvalid;
	logic [31:0]          next_rdata;
	logic [1:0]           next_rresp;
	logic                 next_arready;

	// ********************************************************
	// Start-up sequence
	// ********************************************************
	// The strap pins are read in the first cycle after reset
	// is released, never under reset itself, so a strap level
	// is a sampled value and not a reset constant.
	assign strap_load = (state == ST_STRAP);
	assign next_state = strap_load ? ST_RUN : state;
	assign run_next   = (next_state == ST_RUN);
	assign next_strap = strap_load ? startup_strap : strap_q;
	assign strap_default = ddstw_default(startup_strap);

	// Two states suffice: one cycle to take the straps, then
	// normal running until reset is asserted again.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state   <= ST_STRAP;
			strap_q <= '0;
		end
		else
		begin
			state   <= next_state;
			strap_q <= next_strap;
		end
	end

	// ********************************************************
	// Write channel capture
	// ********************************************************
	// Address and data are taken independently, in any order;
	// the write is performed once both are held.
	assign aw_take  = s_axi_awvalid & s_axi_awready;
	assign w_take   = s_axi_wvalid & s_axi_wready;
	assign do_write = aw_got & w_got & ~s_axi_bvalid;

	assign next_aw_got  = do_write ? 1'b0 : (aw_got | aw_take);
	assign next_w_got   = do_write ? 1'b0 : (w_got | w_take);
	assign next_aw_addr = aw_take ? s_axi_awaddr : aw_addr_q;
	assign next_w_data  = w_take ? s_axi_wdata : w_data_q;
	assign next_w_strb  = w_take ? s_axi_wstrb : w_strb_q;

	// Both readies stay low while a response waits, so one write
	// at most is in flight and the held address cannot be
	// overwritten by the next request.
	assign next_bvalid  = do_write | (s_axi_bvalid & ~s_axi_bready);
	assign next_awready = run_next & ~next_aw_got & ~next_bvalid;
	assign next_wready  = run_next & ~next_w_got & ~next_bvalid;

	// ********************************************************
	// Write decode
	// ********************************************************
	// Only lane 0 carries register data; the upper lanes hit
	// bits that read as zero, so their strobes are ignored.
	assign wr_slot  = ddstw_slot(aw_addr_q);
	assign wr_lane0 = do_write & w_strb_q[0];
	assign wr_unmapped = (wr_slot == SLOT_NONE);
	assign next_bresp  = wr_unmapped ? RESP_DECERR : RESP_OKAY;

	// ********************************************************
	// Write channel registers
	// ********************************************************
	// The response code is latched only when the write is done,
	// so it holds still while bvalid waits for the master.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got        <= 1'b0;
			w_got         <= 1'b0;
			aw_addr_q     <= '0;
			w_data_q      <= WORD_ZERO;
			w_strb_q      <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end
		else
		begin
			aw_got        <= next_aw_got;
			w_got         <= next_w_got;
			aw_addr_q     <= next_aw_addr;
			w_data_q      <= next_w_data;
			w_strb_q      <= next_w_strb;
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
			s_axi_bvalid  <= next_bvalid;
			if (do_write)
				s_axi_bresp <= next_bresp;
		end
	end

	// ********************************************************
	// Byte registers
	// ********************************************************
	// Each byte takes effect the moment it is written. Software
	// that needs a clean jump between two distant tuning words
	// must accept the intermediate words seen between bytes.
	for (genvar g = 0; g < NUM_BYTES; g++)
	begin : g_byte
		logic       ld;
		logic       wr;
		logic [7:0] wd;

		assign ld = strap_load && (g < NUM_FTW_B);
		assign wr = wr_lane0 && (wr_slot == 4'(g));
		// The top two bits of the high phase byte are not stored,
		// so they read back as zero.
		assign wd = (g == NUM_BYTES - 1)
			? (w_data_q[7:0] & POW_HIGH_MASK)
			: w_data_q[7:0];

		ddstw_bytereg u_byte
		(
			.aclk     (aclk),
			.aresetn  (aresetn),
			.load     (ld),
			.load_val (strap_default[g*8 +: 8]),
			.wr       (wr),
			.wdata    (wd),
			.q        (byte_q[g])
		);
	end

	// ********************************************************
	// Word assembly
	// ********************************************************
	// Least significant byte sits at the lowest index.
	assign cfg.frequency_tuning_word = {
		byte_q[5], byte_q[4], byte_q[3],
		byte_q[2], byte_q[1], byte_q[0]
	};
	assign cfg.phase_offset_word = {
		byte_q[7][5:0], byte_q[6]
	};

	// ********************************************************
	// Synthesis core
	// ********************************************************
	// The phase offset is applied combinationally to the top
	// bits, so a large offset step lands in one cycle; any
	// amplitude glitch on octant crossings is downstream.
	ddstw_accum u_accum
	(
		.aclk      (aclk),
		.aresetn   (aresetn),
		.cfg       (cfg),
		.phase_out (dds_phase)
	);

	// ********************************************************
	// Read path
	// ********************************************************
	assign ar_take = s_axi_arvalid & s_axi_arready;
	assign rd_slot = ddstw_slot(s_axi_araddr);

	// ********************************************************
	// Read decode
	// ********************************************************
	// Live readback shows only the top eight phase bits, enough
	// to watch the output advance without a wide read.
	assign rd_is_byte    = (rd_slot < 4'(NUM_BYTES));
	assign rd_is_live    = (rd_slot == SLOT_PHASE_NOW);
	assign rd_is_strap   = (rd_slot == SLOT_STRAP);
	assign rd_unmapped   = (rd_slot == SLOT_NONE);
	assign rd_byte_word  = {24'h0, byte_q[rd_slot[2:0]]};
	assign rd_live_word  = {24'h0, dds_phase[POW_W-1 -: 8]};
	assign rd_strap_word = {28'h0, strap_q};

	assign rd_word = rd_is_byte ? rd_byte_word
		: rd_is_live ? rd_live_word
		: rd_is_strap ? rd_strap_word
		: WORD_ZERO;

	assign next_rvalid  = ar_take | (s_axi_rvalid & ~s_axi_rready);
	assign next_arready = run_next & ~next_rvalid;
	assign next_rdata   = ar_take ? rd_word : s_axi_rdata;
	assign next_rresp   = ar_take
		? (rd_unmapped ? RESP_DECERR : RESP_OKAY)
		: s_axi_rresp;

	// ********************************************************
	// Read response registers
	// ********************************************************
	// Read data is captured at the handshake and then held, so a
	// slow master sees one stable word however long it waits.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= WORD_ZERO;
			s_axi_rresp   <= RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end
	end

endmodule

`default_nettype wire

// ---- ddstw_top_sva.sv ----
`timescale 1ns/1ps
`default_nettype none

module ddstw_top_sva
(
	input wire logic                          aclk,
	input wire logic                          aresetn,
	input wire logic                          s_axi_awvalid,
	input wire logic                          s_axi_awready,
	input wire logic                          s_axi_wvalid,
	input wire logic                          s_axi_wready,
	input wire logic [1:0]                    s_axi_bresp,
	input wire logic                          s_axi_bvalid,
	input wire logic                          s_axi_bready,
	input wire logic                          s_axi_arvalid,
	input wire logic                          s_axi_arready,
	input wire logic [31:0]                   s_axi_rdata,
	input wire logic [1:0]                    s_axi_rresp,
	input wire logic                          s_axi_rvalid,
	input wire logic                          s_axi_rready,
	input wire logic [ddstw_pkg::POW_W-1:0]   dds_phase
);
	import ddstw_pkg::*;

	// *****
	// Handshake sequences and checks
	// *****
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	sequence s_b_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence

	a_write_answer: assert property (s_wr_both |-> ##2 s_axi_bvalid)
		else $error("write got no response");
	a_b_hold: assert property
		(s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not released");
	a_b_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	a_read_answer: assert property
		(s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read got no data one cycle later");
	a_r_hold: assert property
		(s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_r_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");
	a_r_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data above byte not zero");
	// Reset has to be watched while it is asserted, so it cannot disable this.
	a_reset_clear: assert property (@(posedge aclk) disable iff (1'h0)
		!aresetn |=> dds_phase == 14'h0 && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs not cleared by reset");
endmodule

`default_nettype wire

// ---- ddstw_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin \
	n_mismatch++; $display("Error %s exp %h got %h", n, e, s); end end

module ddstw_tb_top;
	import ddstw_pkg::*;

	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic [11:0] awaddr = 12'h0;
	logic [11:0] araddr = 12'h0;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'h0;
	logic        wvalid = 1'h0;
	logic        bready = 1'h0;
	logic        arvalid = 1'h0;
	logic        rready = 1'h0;
	logic [3:0]  strap = 4'h0;
	logic [3:0]  wstrb = 4'hF;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [13:0] dds_phase;
	int          n_mismatch = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          seed = 32'h2B45;

	ddstw_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.startup_strap(strap), .dds_phase(dds_phase));

	always #5 aclk = ~aclk;

	// The whole run needs well under a thousand cycles.
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			$display("Error timeout exp %0d got %0d", 0, cyc);
			n_mismatch++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// *****
	// Bus master
	// *****
	task automatic wchk(input logic [9:0] ix, input logic [7:0] d,
		input logic [1:0] er);
		logic ad;
		logic wd;
		ad = 1'h0;
		wd = 1'h0;
		@(posedge aclk);
		awaddr <= {ix, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(ad && wd))
		begin
			@(posedge aclk);
			if (awready === 1'h1)
			begin
				ad = 1'h1;
				awvalid <= 1'h0;
			end
			if (wready === 1'h1)
			begin
				wd = 1'h1;
				wvalid <= 1'h0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'h1);
		bready <= 1'h0;
		`CHK("bresp", er, bresp)
	endtask

	task automatic rchk(input logic [9:0] ix, input logic [31:0] e,
		input logic [1:0] er);
		@(posedge aclk);
		araddr <= {ix, 2'h0};
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		do @(posedge aclk); while (rvalid !== 1'h1);
		rready <= 1'h0;
		`CHK("rdata", e, rdata)
		`CHK("rresp", er, rresp)
	endtask

	task automatic step_chk(input logic [13:0] k);
		logic [13:0] p;
		@(posedge aclk);
		p = dds_phase;
		repeat (8)
		begin
			@(posedge aclk);
			`CHK("phase step", k, 14'(dds_phase - p))
			p = dds_phase;
		end
	endtask

	// *****
	// Scenarios
	// *****
	initial
	begin
		logic [7:0]  v;
		logic [13:0] k;
		logic [13:0] kn;
		logic [13:0] p;
		logic [47:0] dflt;
		logic [13:0] dp;
		for (int i = 0; i < 2; i++)
		begin
			aresetn <= 1'h0;
			strap <= 4'($random(seed));
			repeat (3) @(posedge aclk);
			aresetn <= 1'h1;
			dflt = {4'h0, strap, 40'h0};
			rchk(IDX_STRAP_RD, {28'h0, strap}, RESP_OKAY);
			for (int b = 0; b < 6; b++)
				rchk(IDX_TW_BYTE0 + 10'(b), 32'(dflt[8*b+:8]), RESP_OKAY);
			rchk(IDX_PHASE_HIGH, 32'h0, RESP_OKAY);
		end
		repeat (2)
			for (int b = 0; b < 8; b++)
			begin
				v = 8'($random(seed));
				wchk(IDX_TW_BYTE0 + 10'(b), v, RESP_OKAY);
				if (b == 7)
					v = v & POW_HIGH_MASK;
				rchk(IDX_TW_BYTE0 + 10'(b), {24'h0, v}, RESP_OKAY);
			end
		rchk(10'h1A5, 32'h0, RESP_DECERR);
		wchk(10'h1B0, 8'h5A, RESP_DECERR);
		wchk(IDX_STRAP_RD, ~{4'h0, strap}, RESP_OKAY);
		rchk(IDX_STRAP_RD, {28'h0, strap}, RESP_OKAY);
		// Low bytes at zero make the top fourteen bits step by exactly k.
		for (int b = 0; b < 4; b++)
			wchk(IDX_TW_BYTE0 + 10'(b), 8'h0, RESP_OKAY);
		k = 14'($random(seed));
		wchk(IDX_TW_BYTE4, {k[5:0], 2'h0}, RESP_OKAY);
		wchk(IDX_TW_BYTE5, k[13:6], RESP_OKAY);
		step_chk(k);
		v = 8'($random(seed));
		kn = {v, k[5:0]};
		fork
			wchk(IDX_TW_BYTE5, v, RESP_OKAY);
			begin
				@(posedge aclk);
				p = dds_phase;
				repeat (8)
				begin
					@(posedge aclk);
					dp = 14'(dds_phase - p);
					`CHK("phase jump", 1'h1, dp == k || dp == kn)
					p = dds_phase;
				end
			end
		join
		step_chk(kn);
		wchk(IDX_TW_BYTE4, 8'h0, RESP_OKAY);
		wchk(IDX_TW_BYTE5, 8'h0, RESP_OKAY);
		wchk(IDX_PHASE_LOW, 8'h0, RESP_OKAY);
		wchk(IDX_PHASE_HIGH, 8'h0, RESP_OKAY);
		repeat (2) @(posedge aclk);
		p = dds_phase;
		v = 8'($random(seed));
		wchk(IDX_PHASE_LOW, v, RESP_OKAY);
		wchk(IDX_PHASE_HIGH, 8'hFF, RESP_OKAY);
		repeat (2) @(posedge aclk);
		kn = 14'(p + {6'h3F, v});
		`CHK("offset", kn, dds_phase)
		rchk(IDX_PHASE_NOW, {24'h0, kn[13:6]}, RESP_OKAY);
		// A write with lane 0 switched off is answered but stores nothing.
		wstrb <= 4'h0;
		wchk(IDX_PHASE_LOW, ~v, RESP_OKAY);
		wstrb <= 4'hF;
		rchk(IDX_PHASE_LOW, {24'h0, v}, RESP_OKAY);
		give_verdict();
	end
endmodule

bind ddstw_top ddstw_top_sva u_sva (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .dds_phase(dds_phase));

`default_nettype wire
